// ---- rtl/pmta_pkg.sv ----
// Package with constants and types for the program memory table access unit.
package pmta_pkg;
   localparam int PMTA_ADDR_W = 16;
   localparam int PMTA_WORD_W = 16;
   localparam int PMTA_BYTE_W = 8;
   localparam logic [15:0] PMTA_PTR_RST = 16'h0000;
   localparam logic [15:0] PMTA_LATCH_RST = 16'h0000;
   localparam logic [1:0] PMTA_EXT_CYCLES = 2'h2;
   localparam logic [1:0] PMTA_NOVPP_CYCLES = 2'h2;
   localparam int PMTA_PIN_SRC = 3;
   localparam int PMTA_PERIPH_W = 8;

   // Instruction codes presented by the core.
   typedef enum logic [2:0] {
      PMTA_OP_NONE = 3'h0,
      PMTA_OP_WORD_READ = 3'h1,
      PMTA_OP_WORD_WRITE = 3'h2,
      PMTA_OP_BYTE_READ = 3'h3,
      PMTA_OP_BYTE_WRITE = 3'h4,
      PMTA_OP_PTR_LOAD = 3'h5
   } pmta_op_t;

   typedef enum {
      PMTA_IDLE,
      PMTA_RD_FETCH,
      PMTA_EXT_WR,
      PMTA_NOVPP_WR,
      PMTA_LONG_WR,
      PMTA_EXT_WAIT
   } pmta_state_t;
endpackage : pmta_pkg

// ---- rtl/pmta_table_access.sv ----
// Table transfer unit moving words between program memory and data memory.
`timescale 1ns/1ps
// Behaviour
// - Word read returns latch byte, then refills latch.
// - Pointer increments after transfer when operand set.
// - Internal write starts long write, stalls core.
// - Only interrupt or reset ends long write.
// - Ending needs enable and flag both set.
// - Pin/timer source end clears highest flag.
// - Pending interrupt aborts internal write as no-op.
// - Peripheral source flag stays set.
// - Vector only when inhibit bit clear.
// - Peripheral enabled, flagged, uninhibited ends and vectors.
// - No programming voltage gives plain two-cycle write.
// - External write takes two cycles, data second.
// - Inhibited external write waits for flag.
// - First read returns stale latch contents.
// - Write stores whole latch at pointer address.
// - External reads use separate read latch.
module pmta_table_access #(
   parameter int ADDR_W = 16,
   parameter int PERIPH_W = 8
) (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire pmta_pkg::pmta_op_t op_i,
   input wire logic op_valid_i,
   input wire logic byte_sel_i,
   input wire logic incr_i,
   input wire logic [7:0] wr_data_i,
   input wire logic [15:0] ptr_load_i,
   input wire logic ext_mem_i,
   input wire logic vpp_present_i,
   input wire logic global_vector_inhibit_i,
   input wire logic [2:0] pin_irq_en_i,
   input wire logic [2:0] pin_irq_flag_i,
   input wire logic [PERIPH_W-1:0] periph_irq_en_i,
   input wire logic [PERIPH_W-1:0] periph_irq_flag_i,
   input wire logic [15:0] mem_rdata_i,
   output logic [7:0] rd_data_o,
   output logic rd_valid_o,
   output logic stall_o,
   output logic vector_o,
   output logic [2:0] pin_flag_clr_o,
   output logic [ADDR_W-1:0] mem_addr_o,
   output logic [15:0] mem_wdata_o,
   output logic int_prog_o,
   output logic ext_we_o,
   output logic mem_re_o,
   output logic [ADDR_W-1:0] program_word_pointer_o,
   output logic [15:0] transfer_latch_o
);
   import pmta_pkg::*;

   // Lowest index is the highest priority pin or timer source.
   function automatic logic [2:0] pmta_first(input logic [2:0] req);
      logic [2:0] res;
      res = 3'h0;
      if (req[0]) begin
         res = 3'h1;
      end else if (req[1]) begin
         res = 3'h2;
      end else if (req[2]) begin
         res = 3'h4;
      end
      return res;
   endfunction : pmta_first

   // Pointer after a transfer: one on when the increment operand is set.
   function automatic logic [ADDR_W-1:0] pmta_step(input logic [ADDR_W-1:0] ptr, input logic inc);
      logic [ADDR_W-1:0] res;
      res = ptr;
      if (inc) begin
         res = ptr + ADDR_W'(1);
      end
      return res;
   endfunction : pmta_step

   // Chooses the high latch byte when the select is set, otherwise the low byte.
   function automatic logic [7:0] pmta_pick(input logic [15:0] word, input logic sel);
      logic [7:0] res;
      res = word[7:0];
      if (sel) begin
         res = word[15:8];
      end
      return res;
   endfunction : pmta_pick

   pmta_state_t state_r, state_nxt;
   logic [ADDR_W-1:0] ptr_r, ptr_nxt;
   logic [15:0] wr_latch_r, wr_latch_nxt;
   logic [15:0] rd_latch_r, rd_latch_nxt;
   logic [7:0] rd_data_r, rd_data_nxt;
   logic rd_valid_r, rd_valid_nxt;
   logic vector_r, vector_nxt;
   logic [2:0] clr_r, clr_nxt;
   logic [ADDR_W-1:0] addr_r, addr_nxt;
   logic [15:0] wdata_r, wdata_nxt;
   logic int_prog_r, int_prog_nxt;
   logic ext_we_r, ext_we_nxt;
   logic re_r, re_nxt;
   logic incr_r, incr_nxt;
   logic [1:0] cnt_r, cnt_nxt;
   logic [2:0] pin_act;
   logic periph_act;
   logic any_act;
   logic [15:0] read_src;

   // Sources able to end a long write need enable and flag both set.
   assign pin_act = pin_irq_en_i & pin_irq_flag_i;
   assign periph_act = |(periph_irq_en_i & periph_irq_flag_i);
   assign any_act = (|pin_act) | periph_act;
   // Internal reads share the write latch; external reads use their own.
   assign read_src = ext_mem_i ? rd_latch_r : wr_latch_r;

   // Sequencer, pointer and latch next-state logic.
   always_comb begin
      state_nxt = state_r;
      ptr_nxt = ptr_r;
      wr_latch_nxt = wr_latch_r;
      rd_latch_nxt = rd_latch_r;
      rd_data_nxt = rd_data_r;
      rd_valid_nxt = 1'b0;
      vector_nxt = 1'b0;
      clr_nxt = 3'h0;
      addr_nxt = addr_r;
      wdata_nxt = wdata_r;
      int_prog_nxt = 1'b0;
      ext_we_nxt = 1'b0;
      re_nxt = 1'b0;
      incr_nxt = incr_r;
      cnt_nxt = cnt_r;
      case (state_r)
         PMTA_IDLE: begin
            if (op_valid_i) begin
               case (op_i)
                  PMTA_OP_PTR_LOAD: begin
                     ptr_nxt = ptr_load_i[ADDR_W-1:0];
                  end
                  PMTA_OP_BYTE_READ: begin
                     rd_data_nxt = pmta_pick(read_src, byte_sel_i);
                     rd_valid_nxt = 1'b1;
                  end
                  PMTA_OP_BYTE_WRITE: begin
                     if (byte_sel_i) begin
                        wr_latch_nxt[15:8] = wr_data_i;
                     end else begin
                        wr_latch_nxt[7:0] = wr_data_i;
                     end
                  end
                  PMTA_OP_WORD_READ: begin
                     // Byte goes out first from the old latch, so the first read is stale.
                     rd_data_nxt = pmta_pick(read_src, byte_sel_i);
                     rd_valid_nxt = 1'b1;
                     addr_nxt = ptr_r;
                     re_nxt = 1'b1;
                     incr_nxt = incr_i;
                     state_nxt = PMTA_RD_FETCH;
                  end
                  PMTA_OP_WORD_WRITE: begin
                     if (byte_sel_i) begin
                        wr_latch_nxt[15:8] = wr_data_i;
                     end else begin
                        wr_latch_nxt[7:0] = wr_data_i;
                     end
                     addr_nxt = ptr_r;
                     incr_nxt = incr_i;
                     if (ext_mem_i) begin
                        cnt_nxt = PMTA_EXT_CYCLES - 2'h1;
                        state_nxt = (global_vector_inhibit_i && (|pin_irq_en_i) && !(|pin_act))
                           ? PMTA_EXT_WAIT : PMTA_EXT_WR;
                     end else if (any_act) begin
                        // Pending interrupt turns the write into a no-operation.
                        clr_nxt = pmta_first(pin_act);
                     end else if (!vpp_present_i) begin
                        cnt_nxt = PMTA_NOVPP_CYCLES - 2'h1;
                        state_nxt = PMTA_NOVPP_WR;
                     end else begin
                        wdata_nxt = wr_latch_nxt;
                        int_prog_nxt = 1'b1;
                        state_nxt = PMTA_LONG_WR;
                     end
                  end
                  default: begin
                  end
               endcase
            end
         end
         PMTA_RD_FETCH: begin
            // Latch refill from the addressed program word.
            if (ext_mem_i) begin
               rd_latch_nxt = mem_rdata_i;
            end else begin
               wr_latch_nxt = mem_rdata_i;
            end
            ptr_nxt = pmta_step(ptr_r, incr_r);
            state_nxt = PMTA_IDLE;
         end
         PMTA_EXT_WAIT: begin
            // Inhibited external write waits for a flag, then clears it.
            if (|pin_act) begin
               clr_nxt = pmta_first(pin_act);
               state_nxt = PMTA_EXT_WR;
            end
         end
         PMTA_EXT_WR: begin
            // The strobe is registered one edge early so that it stands in the last write cycle.
            if (cnt_r != 2'h0) begin
               cnt_nxt = cnt_r - 2'h1;
               if (cnt_r == 2'h1) begin
                  wdata_nxt = wr_latch_r;
                  ext_we_nxt = 1'b1;
               end
            end else begin
               ptr_nxt = pmta_step(ptr_r, incr_r);
               state_nxt = PMTA_IDLE;
            end
         end
         PMTA_NOVPP_WR: begin
            if (cnt_r != 2'h0) begin
               cnt_nxt = cnt_r - 2'h1;
            end else begin
               ptr_nxt = pmta_step(ptr_r, incr_r);
               state_nxt = PMTA_IDLE;
            end
         end
         PMTA_LONG_WR: begin
            int_prog_nxt = 1'b1;
            if (any_act) begin
               // Only an enabled, flagged source ends the cycle.
               int_prog_nxt = 1'b0;
               vector_nxt = !global_vector_inhibit_i;
               clr_nxt = pmta_first(pin_act);
               ptr_nxt = pmta_step(ptr_r, incr_r);
               state_nxt = PMTA_IDLE;
            end
         end
         default: begin
            state_nxt = PMTA_IDLE;
         end
      endcase
   end

   // State registers.
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r <= PMTA_IDLE;
         ptr_r <= ADDR_W'(PMTA_PTR_RST);
         wr_latch_r <= PMTA_LATCH_RST;
         rd_latch_r <= PMTA_LATCH_RST;
         rd_data_r <= 8'h00;
         rd_valid_r <= 1'b0;
         vector_r <= 1'b0;
         clr_r <= 3'h0;
         addr_r <= '0;
         wdata_r <= 16'h0000;
         int_prog_r <= 1'b0;
         ext_we_r <= 1'b0;
         re_r <= 1'b0;
         incr_r <= 1'b0;
         cnt_r <= 2'h0;
      end else begin
         state_r <= state_nxt;
         ptr_r <= ptr_nxt;
         wr_latch_r <= wr_latch_nxt;
         rd_latch_r <= rd_latch_nxt;
         rd_data_r <= rd_data_nxt;
         rd_valid_r <= rd_valid_nxt;
         vector_r <= vector_nxt;
         clr_r <= clr_nxt;
         addr_r <= addr_nxt;
         wdata_r <= wdata_nxt;
         int_prog_r <= int_prog_nxt;
         ext_we_r <= ext_we_nxt;
         re_r <= re_nxt;
         incr_r <= incr_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // Outputs straight from flip-flops; stall covers every busy state.
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         stall_o <= 1'b0;
      end else begin
         stall_o <= (state_nxt != PMTA_IDLE);
      end
   end

   assign rd_data_o = rd_data_r;
   assign rd_valid_o = rd_valid_r;
   assign vector_o = vector_r;
   assign pin_flag_clr_o = clr_r;
   assign mem_addr_o = addr_r;
   assign mem_wdata_o = wdata_r;
   assign int_prog_o = int_prog_r;
   assign ext_we_o = ext_we_r;
   assign mem_re_o = re_r;
   assign program_word_pointer_o = ptr_r;
   assign transfer_latch_o = wr_latch_r;
endmodule : pmta_table_access

// ---- testbench/pmta_table_access_sva.sv ----
// Assertion checker for the table access unit ports.
`timescale 1ns/1ps
module pmta_table_access_sva
   import pmta_pkg::*;
#(
   parameter int ADDR_W = 16,
   parameter int PERIPH_W = 8
) (
   input wire logic core_clk_i, rst_n_i, op_valid_i, ext_mem_i, vpp_present_i, global_vector_inhibit_i,
   input wire pmta_pkg::pmta_op_t op_i,
   input wire logic [15:0] ptr_load_i,
   input wire logic [2:0] pin_irq_en_i, pin_irq_flag_i, pin_flag_clr_o,
   input wire logic [PERIPH_W-1:0] periph_irq_en_i, periph_irq_flag_i,
   input wire logic stall_o, vector_o, int_prog_o, ext_we_o, mem_re_o, rd_valid_o,
   input wire logic [ADDR_W-1:0] program_word_pointer_o
);
   logic [2:0] pin_act;
   logic [2:0] low1;
   logic per_act;
   logic src;
   logic wr;
   // Active sources, the highest-priority pin source and a taken word write.
   assign pin_act = pin_irq_en_i & pin_irq_flag_i;
   assign low1 = pin_act & (~pin_act + 3'h1);
   assign per_act = |(periph_irq_en_i & periph_irq_flag_i);
   assign src = per_act || (pin_act != 3'h0);
   assign wr = op_valid_i && !stall_o && (op_i == PMTA_OP_WORD_WRITE);
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_n_i);
   chk_rd_fetch: assert property (op_valid_i && !stall_o && op_i == PMTA_OP_WORD_READ |=> mem_re_o && rd_valid_o)
      else $error("word read did not answer and fetch");
   chk_ptr_step: assert property (!$stable(program_word_pointer_o) |->
      program_word_pointer_o == $past(program_word_pointer_o) + 1'b1 || program_word_pointer_o == $past(ptr_load_i))
      else $error("pointer moved by other than one or a load");
   chk_ext_cycles: assert property (wr && ext_mem_i && !global_vector_inhibit_i && !src |-> ##2 ext_we_o)
      else $error("external write strobe not in second cycle");
   chk_long_start: assert property (wr && !ext_mem_i && vpp_present_i && !src |=> int_prog_o && stall_o)
      else $error("internal write did not start long write");
   chk_long_hold: assert property (int_prog_o && !src |=> int_prog_o)
      else $error("long write ended without a source");
   chk_long_end: assert property (int_prog_o && src |=> !int_prog_o && vector_o == !$past(global_vector_inhibit_i))
      else $error("long write end or vectoring wrong");
   chk_pin_clear: assert property (int_prog_o && src |=> pin_flag_clr_o == $past(low1))
      else $error("wrong flag clear on long write end");
   chk_write_abort: assert property (wr && !ext_mem_i && pin_act != 3'h0 |=> !int_prog_o && pin_flag_clr_o == $past(low1))
      else $error("pending source did not abort write");
   chk_no_vpp: assert property (wr && !ext_mem_i && !vpp_present_i && !src |=> !int_prog_o [*2])
      else $error("write without voltage started long write");
   cover property (int_prog_o ##1 !int_prog_o);
   cover property (ext_we_o);
   cover property (vector_o);
endmodule : pmta_table_access_sva
bind pmta_table_access pmta_table_access_sva #(.ADDR_W(ADDR_W), .PERIPH_W(PERIPH_W)) i_sva (.*);

// ---- testbench/pmta_prog_mem_model.sv ----
// Behavioural program memory answering reads and external write strobes.
`timescale 1ns/1ps
module pmta_prog_mem_model (
   input wire logic core_clk_i,
   input wire logic mem_re_o,
   input wire logic ext_we_o,
   input wire logic [15:0] mem_addr_o,
   input wire logic [15:0] mem_wdata_o,
   output logic [15:0] mem_rdata_i
);
   logic [15:0] mem [0:15];
   logic re_d;
   // Each word starts with a pattern built from its address.
   initial begin
      re_d = 1'b0;
      for (int k = 0; k < 16; k++) begin
         mem[k] = {4'hC, k[3:0], 4'h3, k[3:0]};
      end
   end
   // External writes land on the strobe; the read strobe is kept one cycle.
   always @(posedge core_clk_i) begin
      re_d <= mem_re_o;
      if (ext_we_o) begin
         mem[mem_addr_o[3:0]] <= mem_wdata_o;
      end
   end
   // Outside a read the bus shows the inverse, so stale data never matches.
   assign mem_rdata_i = (mem_re_o || re_d) ? mem[mem_addr_o[3:0]] : ~mem[mem_addr_o[3:0]];
endmodule : pmta_prog_mem_model

// ---- testbench/pmta_table_access_tb_top.sv ----
// Testbench for the table access unit.
`timescale 1ns/1ps
module pmta_table_access_tb_top;
   import pmta_pkg::*;
   logic core_clk_i, rst_n_i, op_valid_i, byte_sel_i, incr_i, ext_mem_i, vpp_present_i, global_vector_inhibit_i;
   logic rd_valid_o, stall_o, vector_o, int_prog_o, ext_we_o, mem_re_o, vec_seen, prog_seen, seen_clr;
   pmta_op_t op_i;
   logic [7:0] wr_data_i, rd_data_o, rd_cap, periph_irq_en_i, periph_irq_flag_i;
   logic [15:0] ptr_load_i, mem_rdata_i, mem_addr_o, mem_wdata_o, program_word_pointer_o, transfer_latch_o;
   logic [2:0] pin_irq_en_i, pin_irq_flag_i, pin_flag_clr_o, clr_seen;
   int fail_count = 0;
   int num_checks = 0;
   int cyc = 0;
   pmta_table_access i_dut (.*);
   pmta_prog_mem_model i_mem (.core_clk_i(core_clk_i), .mem_re_o(mem_re_o), .ext_we_o(ext_we_o),
      .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i));
   // Clock of 5 ns period.
   initial begin
      core_clk_i = 1'b0;
      forever #2.5 core_clk_i = ~core_clk_i;
   end
   // Capture pulses and cut a hang short.
   always @(posedge core_clk_i) begin
      cyc++;
      if (rd_valid_o === 1'b1) begin
         rd_cap <= rd_data_o;
      end
      if (seen_clr) begin
         clr_seen <= 3'h0;
         vec_seen <= 1'b0;
         prog_seen <= 1'b0;
      end else begin
         clr_seen <= clr_seen | pin_flag_clr_o;
         vec_seen <= vec_seen | vector_o;
         prog_seen <= prog_seen | int_prog_o;
      end
      if (cyc == 20000) begin
         fail_count++;
         results();
      end
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   // Issue one instruction, optionally wait for the unit to go idle.
   task automatic op(input pmta_op_t c, input logic s, input logic i, input logic [7:0] d, input bit w);
      int n;
      @(negedge core_clk_i);
      op_i = c;
      byte_sel_i = s;
      incr_i = i;
      wr_data_i = d;
      op_valid_i = 1'b1;
      @(negedge core_clk_i);
      op_valid_i = 1'b0;
      n = 0;
      while (w && stall_o !== 1'b0 && n < 100) begin
         @(negedge core_clk_i);
         n++;
      end
      @(negedge core_clk_i);
   endtask : op
   // Clears the pulse collectors over one clock edge.
   task automatic clr();
      seen_clr = 1'b1;
      @(negedge core_clk_i);
      seen_clr = 1'b0;
   endtask : clr
   // Long internal write ended by the given sources; flags of disabled sources are set meanwhile.
   task automatic lw(input logic inh, input logic [2:0] pe, input logic [7:0] qe, input logic [2:0] ec, input logic ev);
      clr();
      global_vector_inhibit_i = inh;
      pin_irq_en_i = pe;
      periph_irq_en_i = qe;
      pin_irq_flag_i = ~pe;
      periph_irq_flag_i = ~qe;
      vpp_present_i = 1'b1;
      op(PMTA_OP_WORD_WRITE, 1'b0, 1'b0, 8'h5A, 1'b0);
      repeat (8) @(negedge core_clk_i);
      check(int_prog_o, 1'b1);
      pin_irq_flag_i = pe;
      periph_irq_flag_i = qe;
      repeat (3) @(negedge core_clk_i);
      check(int_prog_o, 1'b0);
      check(clr_seen, ec);
      check(vec_seen, ev);
      pin_irq_en_i = 3'h0;
      periph_irq_en_i = 8'h00;
   endtask : lw
   task automatic results();
      $display("Checks %0d, mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : results
   // Main sequence: reads, external writes, long writes, abort and missing voltage.
   initial begin
      {rst_n_i, op_valid_i, byte_sel_i, incr_i, ext_mem_i, vpp_present_i, global_vector_inhibit_i} = 7'h00;
      op_i = PMTA_OP_NONE;
      {wr_data_i, pin_irq_en_i, pin_irq_flag_i, periph_irq_en_i, periph_irq_flag_i} = 30'h0;
      ptr_load_i = 16'h0003;
      seen_clr = 1'b1;
      repeat (5) @(negedge core_clk_i);
      rst_n_i = 1'b1;
      seen_clr = 1'b0;
      op(PMTA_OP_PTR_LOAD, 1'b0, 1'b0, 8'h00, 1'b1);
      op(PMTA_OP_WORD_READ, 1'b1, 1'b1, 8'h00, 1'b1);
      check(rd_cap, 8'h00);
      check(program_word_pointer_o, 16'h0004);
      op(PMTA_OP_BYTE_READ, 1'b1, 1'b0, 8'h00, 1'b1);
      check(rd_cap, 8'hC3);
      op(PMTA_OP_WORD_READ, 1'b0, 1'b0, 8'h00, 1'b1);
      check(rd_cap, 8'h33);
      check(program_word_pointer_o, 16'h0004);
      ext_mem_i = 1'b1;
      op(PMTA_OP_BYTE_WRITE, 1'b1, 1'b0, 8'hAA, 1'b1);
      op(PMTA_OP_WORD_WRITE, 1'b0, 1'b1, 8'h55, 1'b1);
      check(i_mem.mem[4], 16'hAA55);
      check(program_word_pointer_o, 16'h0005);
      ptr_load_i = 16'h0004;
      op(PMTA_OP_PTR_LOAD, 1'b0, 1'b0, 8'h00, 1'b1);
      op(PMTA_OP_BYTE_WRITE, 1'b0, 1'b0, 8'h66, 1'b1);
      op(PMTA_OP_WORD_READ, 1'b1, 1'b0, 8'h00, 1'b1);
      check(rd_cap, 8'h00);
      op(PMTA_OP_BYTE_READ, 1'b1, 1'b0, 8'h00, 1'b1);
      check(rd_cap, 8'hAA);
      check(transfer_latch_o, 16'hAA66);
      ext_mem_i = 1'b0;
      lw(1'b0, 3'h6, 8'h00, 3'h2, 1'b1);
      lw(1'b1, 3'h1, 8'h00, 3'h1, 1'b0);
      lw(1'b0, 3'h0, 8'h04, 3'h0, 1'b1);
      lw(1'b1, 3'h0, 8'h80, 3'h0, 1'b0);
      clr();
      {pin_irq_en_i, pin_irq_flag_i} = 6'h1B;
      op(PMTA_OP_WORD_WRITE, 1'b0, 1'b0, 8'h11, 1'b1);
      check({prog_seen, clr_seen}, 4'h1);
      {pin_irq_en_i, pin_irq_flag_i} = 6'h00;
      vpp_present_i = 1'b0;
      clr();
      op(PMTA_OP_WORD_WRITE, 1'b0, 1'b0, 8'h22, 1'b1);
      check({prog_seen, stall_o}, 2'h0);
      // Inhibited external write waits for the enabled flag, then writes and clears it.
      ext_mem_i = 1'b1;
      global_vector_inhibit_i = 1'b1;
      pin_irq_en_i = 3'h1;
      clr();
      op(PMTA_OP_WORD_WRITE, 1'b0, 1'b0, 8'h77, 1'b0);
      repeat (4) @(negedge core_clk_i);
      check(stall_o, 1'b1);
      check(i_mem.mem[4], 16'hAA55);
      pin_irq_flag_i = 3'h1;
      repeat (4) @(negedge core_clk_i);
      check(i_mem.mem[4], 16'hAA77);
      check(clr_seen, 3'h1);
      // A reset in mid-run ends a long write that no source ends.
      {pin_irq_en_i, pin_irq_flag_i} = 6'h00;
      ext_mem_i = 1'b0;
      vpp_present_i = 1'b1;
      op(PMTA_OP_WORD_WRITE, 1'b0, 1'b0, 8'h33, 1'b0);
      repeat (4) @(negedge core_clk_i);
      check(int_prog_o, 1'b1);
      rst_n_i = 1'b0;
      @(negedge core_clk_i);
      check({int_prog_o, stall_o}, 2'h0);
      rst_n_i = 1'b1;
      results();
   end
endmodule : pmta_table_access_tb_top
